// file: logic/srp_pkg.sv
// Package with register map, reset values, field layouts and timing of the SYSREF path
package srp_pkg;

  // Register addresses on the three-wire serial port
  localparam logic [6:0] ADDR_DIV = 7'h18;
  localparam logic [6:0] ADDR_RELEASE = 7'h19;
  localparam logic [6:0] ADDR_COUNT = 7'h1A;
  localparam logic [6:0] ADDR_DELAY = 7'h1B;
  localparam logic [6:0] ADDR_MODE = 7'h1C;
  localparam logic [6:0] ADDR_TRIGGER = 7'h70;

  // Reset values
  localparam logic [6:0] RST_DIV_SEL = 7'h2F;
  localparam logic RST_POWERDOWN = 1'b0;
  localparam logic [6:0] RST_RELEASE = 7'h01;
  localparam logic RST_BIAS_STYLE = 1'b1;
  localparam logic [7:0] RST_PULSE_COUNT = 8'h02;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic RST_SOURCE_SEL = 1'b0;
  localparam logic RST_MODE_SEL = 1'b0;

  // Field positions
  localparam int BIT_TOP = 7;
  localparam int BIT_SOURCE_SEL = 1;
  localparam int BIT_MODE_SEL = 0;

  // Serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Global delay step and clock period, in ps
  localparam int DELAY_STEP_PS = 339;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int DELAY_MAX_CODE = 255;
  localparam int DELAY_TAPS = (DELAY_MAX_CODE * DELAY_STEP_PS) / CLK_PERIOD_PS + 1;

  typedef enum logic [1:0] {
    SRP_IDLE = 2'b00,
    SRP_WAIT_ALIGN = 2'b01,
    SRP_RUN = 2'b10
  } srp_fsm_t;

endpackage

// file: logic/srp_delay_line.sv
// Global SYSREF delay: code times one step, rounded down to whole clock cycles
`timescale 1ns/1ps
module srp_delay_line (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  input wire logic [7:0] i_code,
  output logic o_level
);

  typedef struct packed {
    logic [srp_pkg::DELAY_TAPS-1:0] taps;
    logic out;
  } srp_dly_state_t;

  srp_dly_state_t st_reg;
  srp_dly_state_t st_next;
  logic [16:0] delay_ps;
  logic [3:0] delay_cyc;
  logic [srp_pkg::DELAY_TAPS-1:0] tap_in;

  assign delay_ps = 17'(32'(i_code) * srp_pkg::DELAY_STEP_PS);
  assign delay_cyc = 4'(32'(delay_ps) / srp_pkg::CLK_PERIOD_PS);

  // Tap chain, one stage per clock
  genvar g;
  generate
    for (g = 0; g < srp_pkg::DELAY_TAPS; g++) begin : g_tap
      if (g == 0) begin : g_first
        assign tap_in[g] = i_level;
      end else begin : g_next
        assign tap_in[g] = st_reg.taps[g-1];
      end
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.taps = tap_in;
    st_next.out = tap_in[delay_cyc];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.out;

endmodule

// file: logic/srp_sysref_ctrl.sv
// SYSREF divider, release alignment, pulse generator and serial register port
`timescale 1ns/1ps
module srp_sysref_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdat,
  output logic o_spi_sdat,
  output logic o_spi_sdat_oe,
  input wire logic i_ext_pulse_in,
  input wire logic i_ref_out_bias_force,
  output logic o_ref_out,
  output logic o_ref_out_xpt,
  output logic o_sysref_busy,
  output logic o_sysref_powerdown
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] sdi_s;
    logic [2:0] ext_s;
    logic sclk_l;
    logic cs_l;
    logic sdi_l;
    logic ext_l;
    logic [4:0] bit_cnt;
    logic [14:0] shift_in;
    logic [7:0] shift_out;
    logic sdo;
    logic sdo_oe;
    logic [6:0] div_sel;
    logic pd;
    logic [6:0] rel_sel;
    logic bias;
    logic [7:0] pulse_count;
    logic [7:0] delay;
    logic source_sel;
    logic mode_sel;
    logic trig;
    srp_pkg::srp_fsm_t state;
    logic [12:0] div_cnt;
    logic [7:0] align_cnt;
    logic [7:0] left;
    logic level;
    logic xpt;
    logic busy;
  } srp_ctrl_state_t;

  srp_ctrl_state_t st_reg;
  srp_ctrl_state_t st_next;
  logic [12:0] div_ratio;
  logic [7:0] rel_ratio;
  logic align_hit;
  logic sclk_rise;
  logic sclk_fall;
  logic ext_rise;
  logic start;
  logic [6:0] rd_addr;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic fire;

  // Level accepted once second and third stages agree
  function automatic logic srp_filt(input logic [2:0] s, input logic l);
    return (s[1] == s[2]) ? s[2] : l;
  endfunction

  // Four serial SYSREF stages
  function automatic logic [12:0] srp_div_ratio(input logic [6:0] sel);
    logic [12:0] s6;
    logic [12:0] s54;
    logic [12:0] s32;
    logic [12:0] s10;
    s6 = sel[6] ? 13'h0004 : 13'h0002;
    s54 = 13'h0002 << sel[5:4];
    s32 = 13'h0002 << sel[3:2];
    s10 = 13'h0002 + 13'(sel[1:0]);
    return 13'(s6 * s54 * s32 * s10);
  endfunction

  // Two-stage release-alignment divider
  function automatic logic [7:0] srp_rel_ratio(input logic [6:0] sel);
    logic [7:0] hi;
    logic [7:0] lo;
    case (sel[5:3])
      3'h0: hi = 8'h02;
      3'h1: hi = 8'h04;
      3'h2: hi = 8'h06;
      3'h3: hi = 8'h08;
      3'h4: hi = 8'h04;
      3'h5: hi = 8'h08;
      3'h6: hi = 8'h0C;
      default: hi = 8'h10;
    endcase
    lo = 8'h02 + 8'(sel[2:0]);
    return sel[6] ? 8'(hi * lo) : lo;
  endfunction

  // Read-back of the register map
  function automatic logic [7:0] srp_rdata(input srp_ctrl_state_t s, input logic [6:0] a);
    case (a)
      srp_pkg::ADDR_DIV: return {s.pd, s.div_sel};
      srp_pkg::ADDR_RELEASE: return {s.bias, s.rel_sel};
      srp_pkg::ADDR_COUNT: return s.pulse_count;
      srp_pkg::ADDR_DELAY: return s.delay;
      srp_pkg::ADDR_MODE: return {6'h00, s.source_sel, s.mode_sel};
      default: return 8'h00;
    endcase
  endfunction

  assign div_ratio = srp_div_ratio(st_reg.div_sel);
  assign rel_ratio = srp_rel_ratio(st_reg.rel_sel);
  assign rd_addr = {st_reg.shift_in[5:0], srp_filt(st_reg.sdi_s, st_reg.sdi_l)};
  assign wr_addr = st_reg.shift_in[13:7];
  assign wr_data = {st_reg.shift_in[6:0], srp_filt(st_reg.sdi_s, st_reg.sdi_l)};
  assign rd_data = srp_rdata(st_reg, rd_addr);

  always_comb begin
    st_next = st_reg;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    ext_rise = 1'b0;
    start = 1'b0;
    fire = 1'b0;
    align_hit = 1'b0;

    // Pin synchronisers
    st_next.sclk_s = {st_reg.sclk_s[1:0], i_spi_sclk};
    st_next.cs_s = {st_reg.cs_s[1:0], i_spi_cs_n};
    st_next.sdi_s = {st_reg.sdi_s[1:0], i_spi_sdat};
    st_next.ext_s = {st_reg.ext_s[1:0], i_ext_pulse_in};
    st_next.sclk_l = srp_filt(st_reg.sclk_s, st_reg.sclk_l);
    st_next.cs_l = srp_filt(st_reg.cs_s, st_reg.cs_l);
    st_next.sdi_l = srp_filt(st_reg.sdi_s, st_reg.sdi_l);
    st_next.ext_l = srp_filt(st_reg.ext_s, st_reg.ext_l);
    sclk_rise = st_next.sclk_l & ~st_reg.sclk_l;
    sclk_fall = ~st_next.sclk_l & st_reg.sclk_l;
    ext_rise = st_next.ext_l & ~st_reg.ext_l;

    // Free-running release divider marks the common output-clock edge
    if (st_reg.pd) begin
      st_next.align_cnt = 8'h00;
    end else if (st_reg.align_cnt >= rel_ratio - 8'h01) begin
      st_next.align_cnt = 8'h00;
    end else begin
      st_next.align_cnt = st_reg.align_cnt + 8'h01;
    end
    align_hit = ~st_reg.pd & (st_reg.align_cnt == 8'h00);

    // Trigger: serial bit alone, or armed by it and fired by the pin edge
    fire = ~st_reg.pd & st_reg.trig & (st_reg.state == srp_pkg::SRP_IDLE)
      & (st_reg.source_sel ? ext_rise : 1'b1);
    start = fire & (st_reg.mode_sel | (st_reg.pulse_count != 8'h00));

    st_next.level = 1'b0;
    case (st_reg.state)
      srp_pkg::SRP_IDLE: begin
        st_next.div_cnt = 13'h0000;
        // Counted mode consumes the trigger even with a zero count
        if (fire && !st_reg.mode_sel) begin
          st_next.trig = 1'b0;
        end
        if (start) begin
          st_next.state = srp_pkg::SRP_WAIT_ALIGN;
          st_next.left = st_reg.pulse_count;
        end
      end
      srp_pkg::SRP_WAIT_ALIGN: begin
        if (align_hit) begin
          st_next.state = srp_pkg::SRP_RUN;
          st_next.div_cnt = 13'h0000;
        end
      end
      srp_pkg::SRP_RUN: begin
        st_next.level = st_reg.div_cnt < (div_ratio >> 1);
        if (st_reg.div_cnt >= div_ratio - 13'h0001) begin
          st_next.div_cnt = 13'h0000;
          if (!st_reg.mode_sel) begin
            st_next.left = st_reg.left - 8'h01;
            if (st_reg.left == 8'h01) begin
              st_next.state = srp_pkg::SRP_IDLE;
            end
          end else if (!st_reg.trig) begin
            st_next.state = srp_pkg::SRP_IDLE;
          end
        end else begin
          st_next.div_cnt = st_reg.div_cnt + 13'h0001;
        end
      end
      default: begin
        st_next.state = srp_pkg::SRP_IDLE;
      end
    endcase

    if (st_reg.pd) begin
      st_next.state = srp_pkg::SRP_IDLE;
      st_next.level = 1'b0;
      st_next.div_cnt = 13'h0000;
    end

    st_next.busy = st_next.state != srp_pkg::SRP_IDLE;
    st_next.xpt = st_reg.bias
      & (i_ref_out_bias_force | (st_next.state != srp_pkg::SRP_RUN));

    // Serial port: frames counted while chip select is low
    if (st_next.cs_l) begin
      st_next.bit_cnt = 5'h00;
      st_next.sdo_oe = 1'b0;
      st_next.sdo = 1'b0;
    end else if (sclk_rise && (st_reg.bit_cnt < srp_pkg::FRAME_BITS)) begin
      st_next.shift_in = {st_reg.shift_in[13:0], st_next.sdi_l};
      st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      if ((st_reg.bit_cnt == srp_pkg::CMD_BITS - 5'h01) && st_reg.shift_in[6]) begin
        st_next.sdo_oe = 1'b1;
        st_next.sdo = rd_data[7];
        st_next.shift_out = {rd_data[6:0], 1'b0};
      end
      if ((st_reg.bit_cnt == srp_pkg::FRAME_BITS - 5'h01) && !st_reg.shift_in[14]) begin
        case (wr_addr)
          srp_pkg::ADDR_DIV: begin
            st_next.pd = wr_data[srp_pkg::BIT_TOP];
            st_next.div_sel = wr_data[6:0];
          end
          srp_pkg::ADDR_RELEASE: begin
            st_next.bias = wr_data[srp_pkg::BIT_TOP];
            st_next.rel_sel = wr_data[6:0];
          end
          srp_pkg::ADDR_COUNT: begin
            st_next.pulse_count = wr_data;
          end
          srp_pkg::ADDR_DELAY: begin
            st_next.delay = wr_data;
          end
          srp_pkg::ADDR_MODE: begin
            st_next.source_sel = wr_data[srp_pkg::BIT_SOURCE_SEL];
            st_next.mode_sel = wr_data[srp_pkg::BIT_MODE_SEL];
          end
          srp_pkg::ADDR_TRIGGER: begin
            st_next.trig = wr_data[srp_pkg::BIT_TOP];
            if (wr_data[srp_pkg::BIT_TOP]) begin
              st_next.pd = 1'b0;
            end
          end
          default: begin
            st_next.trig = st_next.trig;
          end
        endcase
      end
    end else if (sclk_fall && st_reg.sdo_oe && (st_reg.bit_cnt > srp_pkg::CMD_BITS)
        && (st_reg.bit_cnt < srp_pkg::FRAME_BITS)) begin
      st_next.sdo = st_reg.shift_out[7];
      st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.sclk_s <= 3'h0;
      st_reg.cs_s <= 3'h7;
      st_reg.cs_l <= 1'b1;
      st_reg.div_sel <= srp_pkg::RST_DIV_SEL;
      st_reg.pd <= srp_pkg::RST_POWERDOWN;
      st_reg.rel_sel <= srp_pkg::RST_RELEASE;
      st_reg.bias <= srp_pkg::RST_BIAS_STYLE;
      st_reg.pulse_count <= srp_pkg::RST_PULSE_COUNT;
      st_reg.delay <= srp_pkg::RST_DELAY;
      st_reg.source_sel <= srp_pkg::RST_SOURCE_SEL;
      st_reg.mode_sel <= srp_pkg::RST_MODE_SEL;
      st_reg.state <= srp_pkg::SRP_IDLE;
      st_reg.xpt <= srp_pkg::RST_BIAS_STYLE;
    end else begin
      st_reg <= st_next;
    end
  end

  srp_delay_line u_delay (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(st_reg.level),
    .i_code(st_reg.delay),
    .o_level(o_ref_out)
  );

  assign o_spi_sdat = st_reg.sdo;
  assign o_spi_sdat_oe = st_reg.sdo_oe;
  assign o_ref_out_xpt = st_reg.xpt;
  assign o_sysref_busy = st_reg.busy;
  assign o_sysref_powerdown = st_reg.pd;

endmodule

// file: verification/srp_sysref_ctrl_asserts.sv
// Port assertions for the SYSREF control block
`timescale 1ns/1ps
module srp_sysref_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic o_ref_out,
  input wire logic o_ref_out_xpt,
  input wire logic o_spi_sdat_oe,
  input wire logic o_sysref_busy,
  input wire logic o_sysref_powerdown
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_rst_idle;
    $fell(i_rst) |-> !o_ref_out && o_ref_out_xpt && !o_sysref_busy && !o_spi_sdat_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_pd_no_start;
    $rose(o_sysref_busy) |-> !o_sysref_powerdown;
  endproperty
  a_pd_no_start: assert property (p_pd_no_start) else $error("start while powered down");
  property p_pd_idle;
    o_sysref_powerdown [*2] |-> !o_sysref_busy;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("busy while powered down");
  property p_pd_quiet;
    o_sysref_powerdown [*8] ##1 o_sysref_powerdown [*4] |-> !o_ref_out;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("output active in power down");
  property p_pulse_hi;
    $rose(o_ref_out) |-> o_ref_out [*8];
  endproperty
  a_pulse_hi: assert property (p_pulse_hi) else $error("pulse high too short");
  property p_pulse_lo;
    $fell(o_ref_out) |-> !o_ref_out [*8];
  endproperty
  a_pulse_lo: assert property (p_pulse_lo) else $error("pulse low too short");
  property p_rise_busy;
    $rose(o_ref_out) |-> $past(o_sysref_busy, 2);
  endproperty
  a_rise_busy: assert property (p_rise_busy) else $error("pulse without busy");
  property p_start_low;
    $rose(o_sysref_busy) |-> !o_ref_out;
  endproperty
  a_start_low: assert property (p_start_low) else $error("output high at start");
  property p_end_low;
    $fell(o_sysref_busy) && !o_sysref_powerdown |-> ##3 !o_ref_out [*8];
  endproperty
  a_end_low: assert property (p_end_low) else $error("output active after burst");
endmodule
bind srp_sysref_ctrl srp_sysref_ctrl_asserts i_srp_sysref_ctrl_asserts (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .o_ref_out(o_ref_out),
  .o_ref_out_xpt(o_ref_out_xpt),
  .o_spi_sdat_oe(o_spi_sdat_oe),
  .o_sysref_busy(o_sysref_busy),
  .o_sysref_powerdown(o_sysref_powerdown)
);

// file: verification/srp_host_model.sv
// Three-wire serial host driving register frames
`timescale 1ns/1ps
module srp_host_model (
  input wire logic i_clk,
  input wire logic i_sdat,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdat
);
  logic [15:0] frame_reg;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdat = 1'b0;
  end
  // Sixteen bits, first bit first; each clock phase five system cycles
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
    frame_reg = {rd, a, wd};
    @(negedge i_clk) o_cs_n = 1'b0;
    for (int b = 0; b < 16; b++) begin
      if (rd && b > 7) o_sdat = ~o_sdat;
      else o_sdat = frame_reg[15 - b];
      repeat (5) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      if (b > 7) rdat[15 - b] = i_sdat;
      o_sclk = 1'b0;
    end
    repeat (2) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

// file: verification/srp_sysref_ctrl_tb.sv
// Self-checking bench for the SYSREF control block
`timescale 1ns/1ps
module srp_sysref_ctrl_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ext_pin = 1'b0;
  logic bias_force = 1'b0;
  logic sclk, cs_n, host_sdat, sdat_wire, sdat_out, sdat_oe;
  logic ref_out, ref_xpt, busy, powerdown, bz, ro;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int np, hi, per, lat, last, t_busy, t_rise, t0;
  logic [7:0] rd;
  logic [6:0] ra [7] = '{7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h70, 7'h20};
  logic [7:0] re [7] = '{8'h2F, 8'h81, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  // Divider codes picked in rising ratio order, then the smallest again with a zero count
  logic [6:0] bn [5] = '{7'h00, 7'h09, 7'h1E, 7'h7F, 7'h00};
  logic [7:0] bc [5] = '{8'hFF, 8'h03, 8'h02, 8'h01, 8'h00};
  logic [7:0] bd [5] = '{8'h00, 8'hFF, 8'h1E, 8'h00, 8'h00};
  always #5 i_clk = ~i_clk;
  assign sdat_wire = sdat_oe ? sdat_out : host_sdat;
  srp_sysref_ctrl i_srp_sysref_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_sdat(sdat_wire), .o_spi_sdat(sdat_out),
    .o_spi_sdat_oe(sdat_oe), .i_ext_pulse_in(ext_pin), .i_ref_out_bias_force(bias_force),
    .o_ref_out(ref_out), .o_ref_out_xpt(ref_xpt), .o_sysref_busy(busy),
    .o_sysref_powerdown(powerdown));
  srp_host_model i_srp_host_model (.i_clk(i_clk), .i_sdat(sdat_wire), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_sdat(host_sdat));
  // Pulse monitor sampling settled outputs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    #2;
    if (busy === 1'b1 && bz !== 1'b1) t_busy = cyc;
    if (ref_out === 1'b1 && ro !== 1'b1) begin
      if (np == 0) begin
        lat = cyc - t_busy;
        t_rise = cyc;
      end else per = cyc - last;
      np++;
      last = cyc;
    end
    if (ref_out === 1'b1) hi++;
    bz = busy;
    ro = ref_out;
    if (cyc == 80000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_srp_host_model.xfer(1'b0, a, d, rd);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    i_srp_host_model.xfer(1'b1, a, 8'h00, rd);
    chk("register", exp, rd);
  endtask
  task automatic settle;
    for (int w = 0; w < 30000 && busy !== 1'b0; w++) @(negedge i_clk);
    repeat (12) @(negedge i_clk);
  endtask
  task automatic run(input logic [6:0] ns, input logic [7:0] cnt, input logic [7:0] dly);
    int n;
    int d;
    n = (ns[6] ? 4 : 2) * (2 << ns[5:4]) * (2 << ns[3:2]) * (ns[1:0] + 2);
    d = dly * 339 / 10000;
    wr(7'h18, {1'b0, ns});
    wr(7'h1A, cnt);
    wr(7'h1B, dly);
    np = 0;
    hi = 0;
    wr(7'h70, 8'h80);
    settle();
    chk("pulses", cnt, np);
    chk("high", cnt * n / 2, hi);
    if (cnt > 1) chk("period", n, per);
    if (cnt > 0) chk("latency", 1, lat >= d + 1 && lat <= d + 5);
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    foreach (ra[k]) rchk(ra[k], re[k]);
    wr(7'h1C, 8'hFF);
    rchk(7'h1C, 8'h03);
    wr(7'h20, 8'h55);
    rchk(7'h20, 8'h00);
    wr(7'h1C, 8'h00);
    wr(7'h19, 8'h00);
    foreach (bn[k]) run(bn[k], bc[k], bd[k]);
    wr(7'h1A, 8'h01);
    chk("stale trigger", 0, busy);
    wr(7'h19, 8'h7F);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) wr(7'h19, 8'h76);
      np = 0;
      repeat (k * 37) @(negedge i_clk);
      wr(7'h70, 8'h80);
      settle();
      if (k % 3 == 0) t0 = t_rise;
      chk("align", 0, (t_rise - t0) % (k < 3 ? 144 : 96));
    end
    wr(7'h19, 8'h80);
    wr(7'h1C, 8'h01);
    np = 0;
    wr(7'h70, 8'h80);
    repeat (100) @(negedge i_clk);
    chk("running", 1, busy);
    chk("xpt run", 0, ref_xpt);
    bias_force = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("xpt force", 1, ref_xpt);
    bias_force = 1'b0;
    wr(7'h70, 8'h00);
    repeat (40) @(negedge i_clk);
    chk("stopped", 0, busy);
    chk("many", 1, np > 8);
    wr(7'h19, 8'h00);
    bias_force = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("xpt static", 0, ref_xpt);
    bias_force = 1'b0;
    wr(7'h1C, 8'h02);
    np = 0;
    wr(7'h70, 8'h80);
    repeat (30) @(negedge i_clk);
    chk("ext armed", 0, busy);
    ext_pin = 1'b1;
    repeat (10) @(negedge i_clk);
    settle();
    chk("ext pulses", 1, np);
    ext_pin = 1'b0;
    wr(7'h1C, 8'h00);
    wr(7'h18, 8'h80);
    rchk(7'h18, 8'h80);
    chk("pd", 1, powerdown);
    np = 0;
    wr(7'h70, 8'h80);
    settle();
    chk("pd cleared", 0, powerdown);
    chk("pd run", 1, np);
    conclude();
  end
endmodule
